// [rtl/fsa_flash_mem.sv]
// byte-wide flash array model, one port, registered read data
// assumes the controller gates writes; contents are unknown until erased
`timescale 1ns/1ps
module fsa_flash_mem
  import fsa_pkg::*;
#(
  parameter int AW = 13
) (
  // clock
  input wire logic clk,
  input wire logic ce,
  // array port
  fsa_mem_if.mem bus
);
  logic [7:0] cells [0:(1 << AW) - 1];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk) begin
    if (ce) begin
      if (bus.we) begin
        cells[bus.addr] <= bus.wdata;
      end
      rdata_reg <= cells[bus.addr];
    end
  end

  assign bus.rdata = rdata_reg;
endmodule : fsa_flash_mem

// [rtl/fsa_mem_if.sv]
// signals between the access controller and the flash array
// assumes one clock, read data one cycle after the address
`timescale 1ns/1ps
interface fsa_mem_if #(parameter int AW = 13) ();
  logic [AW-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : fsa_mem_if

// [rtl/fsa_pkg.sv]
// constants shared by the flash sector access block and its memory
// assumes a 16-bit cpu address space with the flash array at its top
package fsa_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] FPCS_IDX = 8'h29;
  localparam logic [7:0] ADDR_IDX = 8'h2a;
  localparam logic [7:0] DATA_IDX = 8'h2b;
  localparam logic [7:0] CMD_IDX = 8'h2c;
  localparam logic [7:0] STAT_IDX = 8'h2d;
  localparam logic [7:0] FPCS_RST = 8'h00;
  // ----------------------------------------------------------------
  // sector layout
  // ----------------------------------------------------------------
  localparam logic [15:0] SECT0_BASE = 16'hf000;
  localparam logic [15:0] SECT1_BASE = 16'he000;
  localparam logic [15:0] SECT1_LAST = 16'hefff;
  localparam logic [15:0] SECT2_LAST = 16'hdfff;
  localparam logic [15:0] ADDR_TOP = 16'hffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ----------------------------------------------------------------
  // commands, replies, link frame
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_OPTION} fsa_op_type;
  localparam logic [7:0] REPLY_BLOCKED = 8'h00;
  localparam logic [7:0] REPLY_DONE = 8'h01;
  localparam logic [7:0] REPLY_REFUSED = 8'h02;
  localparam logic [7:0] REPLY_BUSY = 8'h03;
  localparam int LINK_CMD_BITS = 26;
  localparam int LINK_REPLY_BITS = 8;
  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_PROT = 2;
  localparam int ST_SESSION = 3;
  localparam int ST_VPP = 4;
  localparam int ST_TOOL = 5;
  localparam int ST_SECT = 6;
endpackage : fsa_pkg

// [rtl/fsa_top.sv]
// flash sector access and protection controller with apb registers
// and an in-circuit session link on its own serial clock
// assumes apb master on CLK, tool drives link clock, select pin and reset
`timescale 1ns/1ps
module fsa_top
  import fsa_pkg::*;
#(
  parameter int FLASH_KB = 8
) (
  // system
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // session link
  input wire logic SESSION_SERIAL_CLOCK,
  input wire logic SESSION_SERIAL_DATA_IN,
  output logic SESSION_SERIAL_DATA_OUT,
  output logic SESSION_SERIAL_DATA_OE,
  input wire logic SESSION_SELECT_PROG_VOLTAGE,
  input wire logic TOOL_PRESENT,
  // status pins
  output logic APP_PINS_FREE,
  output logic READOUT_PROTECTED
);
  // ----------------------------------------------------------------
  // sizing
  // ----------------------------------------------------------------
  localparam int FLASH_BYTES = FLASH_KB * 1024;
  localparam int AW = $clog2(FLASH_BYTES);
  localparam logic [15:0] FLASH_BASE = 16'(17'h10000 - 17'(FLASH_BYTES));
  localparam logic [1:0] SECTORS = (FLASH_KB <= 4) ? 2'd1 : (FLASH_KB <= 8) ? 2'd2 : 2'd3;
  localparam logic [5:0] CMD_LAST = 6'(LINK_CMD_BITS - 1);
  localparam logic [5:0] FRAME_LAST = 6'(LINK_CMD_BITS + LINK_REPLY_BITS);

  typedef enum logic [1:0] {S_IDLE, S_READ, S_ERASE} fsa_state_type;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic sel_s1;
    logic sel_s2;
    logic ack_s1;
    logic ack_s2;
    logic [5:0] cnt;
    logic [25:0] shift;
    logic [25:0] hold;
    logic req_tgl;
    logic [7:0] reply_sh;
    logic dout;
    logic oe;
  } fsa_link_type;

  typedef struct packed {
    fsa_state_type state;
    logic [7:0] fpcs;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic refused;
    logic prot;
    logic clear_prot;
    logic from_link;
    logic [15:0] walk;
    logic [15:0] walk_end;
    logic [7:0] reply;
    logic ack_tgl;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic link_pend;
    logic sel_s1;
    logic sel_s2;
    logic tool_s1;
    logic tool_s2;
    logic cpu_pend;
    logic [1:0] cpu_op;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pins_free;
  } fsa_sys_type;

  fsa_link_type l_reg, l_next;
  fsa_sys_type s_reg, s_next;

  fsa_mem_if #(.AW(AW)) mem_bus ();

  fsa_flash_mem #(.AW(AW)) u_mem (
    .clk(CLK),
    .ce(CE),
    .bus(mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  // frame: 26 bits in (op, address, data) msb first, 8 reply bits out,
  // one turnaround edge; the reply is the previous frame's result
  always_comb begin
    l_next = l_reg;
    l_next.rst_s1 = RST_N;
    l_next.rst_s2 = l_reg.rst_s1;
    l_next.sel_s1 = SESSION_SELECT_PROG_VOLTAGE;
    l_next.sel_s2 = l_reg.sel_s1;
    l_next.ack_s1 = s_reg.ack_tgl;
    l_next.ack_s2 = l_reg.ack_s1;
    if (!l_reg.rst_s2) begin
      l_next.cnt = '0;
      l_next.oe = 1'b0;
      l_next.dout = 1'b0;
      l_next.req_tgl = 1'b0;
    end else if (!l_reg.sel_s2) begin
      // frames count only while the select pin is high; tool presence is not checked here
      l_next.cnt = '0;
      l_next.oe = 1'b0;
    end else if (l_reg.cnt <= CMD_LAST) begin
      l_next.shift = {l_reg.shift[24:0], SESSION_SERIAL_DATA_IN};
      if (l_reg.cnt == CMD_LAST) begin
        l_next.hold = {l_reg.shift[24:0], SESSION_SERIAL_DATA_IN};
        l_next.req_tgl = ~l_reg.req_tgl;
      end
      l_next.cnt = l_reg.cnt + 6'd1;
    end else if (l_reg.cnt == FRAME_LAST) begin
      l_next.oe = 1'b0;
      l_next.cnt = '0;
    end else begin
      if (l_reg.cnt == 6'(LINK_CMD_BITS)) begin
        // req_tgl already counts this frame: the previous one is done once ack differs
        l_next.reply_sh = (l_reg.ack_s2 != l_reg.req_tgl) ? s_reg.reply : REPLY_BUSY;
        l_next.dout = l_next.reply_sh[7];
      end else begin
        l_next.dout = l_reg.reply_sh[6];
        l_next.reply_sh = {l_reg.reply_sh[6:0], 1'b0};
      end
      l_next.oe = 1'b1;
      l_next.cnt = l_reg.cnt + 6'd1;
    end
  end

  always_ff @(posedge SESSION_SERIAL_CLOCK) begin
    l_reg <= l_next;
  end

  // ----------------------------------------------------------------
  // system domain
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic hit;
  logic link_evt;
  logic session;
  logic vpp;
  logic s_link;
  logic [1:0] s_op;
  logic [15:0] s_addr;
  logic [7:0] s_data;
  logic in_flash;
  logic prog_ok;
  logic finish;
  logic [7:0] code;
  logic [AW-1:0] m_addr;
  logic m_we;
  logic [7:0] m_wdata;

  always_comb begin
    s_next = s_reg;
    finish = 1'b0;
    code = REPLY_DONE;
    m_addr = s_reg.walk[AW-1:0];
    m_we = 1'b0;
    m_wdata = ERASED_BYTE;
    s_next.req_s1 = l_reg.req_tgl;
    s_next.req_s2 = s_reg.req_s1;
    s_next.req_s3 = s_reg.req_s2;
    s_next.sel_s1 = SESSION_SELECT_PROG_VOLTAGE;
    s_next.sel_s2 = s_reg.sel_s1;
    s_next.tool_s1 = TOOL_PRESENT;
    s_next.tool_s2 = s_reg.tool_s1;
    link_evt = s_reg.req_s2 ^ s_reg.req_s3;
    vpp = s_reg.sel_s2;
    // in-circuit mode needs tool plus select
    session = s_reg.tool_s2 & s_reg.sel_s2;
    s_next.pins_free = ~s_reg.tool_s2;
    if (link_evt) begin
      s_next.link_pend = 1'b1;
    end
    // apb decode, answer one cycle into the access phase
    idx = PADDR[9:2];
    hit = (PADDR[11:10] == 2'b00) && (PADDR[1:0] == 2'b00);
    s_next.pready = 1'b0;
    if (PSEL && PENABLE && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.pslverr = 1'b0;
      s_next.prdata = '0;
      if (!hit) begin
        s_next.pslverr = 1'b1;
      end else if (idx == FPCS_IDX) begin
        s_next.prdata[7:0] = s_reg.fpcs;
      end else if (idx == ADDR_IDX) begin
        s_next.prdata[15:0] = s_reg.addr;
      end else if (idx == DATA_IDX) begin
        s_next.prdata[7:0] = s_reg.rdata;
      end else if (idx == STAT_IDX) begin
        s_next.prdata[ST_BUSY] = (s_reg.state != S_IDLE) | s_reg.cpu_pend;
        s_next.prdata[ST_REFUSED] = s_reg.refused;
        s_next.prdata[ST_PROT] = s_reg.prot;
        s_next.prdata[ST_SESSION] = session;
        s_next.prdata[ST_VPP] = vpp;
        s_next.prdata[ST_TOOL] = s_reg.tool_s2;
        s_next.prdata[ST_SECT+1:ST_SECT] = SECTORS;
      end else if (idx != CMD_IDX) begin
        s_next.pslverr = 1'b1;
      end
    end
    if (PSEL && PENABLE && s_reg.pready && PWRITE && hit) begin
      if (idx == FPCS_IDX) begin
        s_next.fpcs = PWDATA[7:0];
      end else if (idx == ADDR_IDX) begin
        s_next.addr = PWDATA[15:0];
      end else if (idx == DATA_IDX) begin
        s_next.wdata = PWDATA[7:0];
      end else if (idx == CMD_IDX && !s_reg.cpu_pend) begin
        s_next.cpu_pend = 1'b1;
        s_next.cpu_op = PWDATA[1:0];
        s_next.refused = 1'b0;
      end
    end
    // source selection, link first
    s_link = s_reg.link_pend;
    s_op = s_link ? l_reg.hold[25:24] : s_reg.cpu_op;
    s_addr = s_link ? l_reg.hold[23:8] : s_reg.addr;
    s_data = s_link ? l_reg.hold[7:0] : s_reg.wdata;
    // addresses below the fitted sectors miss
    in_flash = s_addr >= FLASH_BASE;
    prog_ok = in_flash && vpp &&
      (s_link ? (session && !s_reg.prot) : (s_addr[15:12] != SECT0_BASE[15:12]));
    case (s_reg.state)
      S_IDLE: begin
        if (s_reg.link_pend || s_reg.cpu_pend) begin
          s_next.from_link = s_link;
          if (s_link) begin
            s_next.link_pend = link_evt;
          end else begin
            s_next.cpu_pend = 1'b0;
          end
          m_addr = s_addr[AW-1:0];
          case (fsa_op_type'(s_op))
            OP_READ: begin
              if (s_link && s_reg.prot) begin
                finish = 1'b1;
                code = REPLY_BLOCKED;
              end else if (!in_flash) begin
                finish = 1'b1;
                code = REPLY_REFUSED;
              end else begin
                s_next.state = S_READ;
              end
            end
            OP_PROG: begin
              finish = 1'b1;
              if (prog_ok) begin
                m_we = 1'b1;
                m_wdata = s_data;
              end else begin
                code = REPLY_REFUSED;
              end
            end
            OP_ERASE: begin
              if (prog_ok) begin
                s_next.state = S_ERASE;
                if (s_addr[15:12] == SECT0_BASE[15:12]) begin
                  s_next.walk = SECT0_BASE;
                  s_next.walk_end = ADDR_TOP;
                end else if (s_addr[15:12] == SECT1_BASE[15:12]) begin
                  s_next.walk = SECT1_BASE;
                  s_next.walk_end = SECT1_LAST;
                end else begin
                  s_next.walk = FLASH_BASE;
                  s_next.walk_end = SECT2_LAST;
                end
              end else begin
                finish = 1'b1;
                code = REPLY_REFUSED;
              end
            end
            default: begin
              // option bit only from a session
              if (!s_link || !session || !vpp) begin
                finish = 1'b1;
                code = REPLY_REFUSED;
              end else if (s_data[0]) begin
                finish = 1'b1;
                s_next.prot = 1'b1;
              end else if (s_reg.prot) begin
                s_next.clear_prot = 1'b1;
                s_next.walk = FLASH_BASE;
                s_next.walk_end = ADDR_TOP;
                s_next.state = S_ERASE;
              end else begin
                finish = 1'b1;
              end
            end
          endcase
        end
      end
      S_READ: begin
        finish = 1'b1;
        code = mem_bus.rdata;
        s_next.rdata = mem_bus.rdata;
        s_next.state = S_IDLE;
      end
      default: begin
        // erase walk, one byte a cycle
        m_we = 1'b1;
        s_next.walk = s_reg.walk + 16'd1;
        if (s_reg.walk == s_reg.walk_end) begin
          finish = 1'b1;
          s_next.state = S_IDLE;
          if (s_reg.clear_prot) begin
            s_next.prot = 1'b0;
            s_next.clear_prot = 1'b0;
          end
        end
      end
    endcase
    if (finish) begin
      if (s_next.from_link) begin
        s_next.reply = code;
        s_next.ack_tgl = ~s_reg.ack_tgl;
      end else if (code == REPLY_REFUSED && s_reg.state == S_IDLE) begin
        s_next.refused = 1'b1;
      end
    end
  end

  assign mem_bus.addr = m_addr;
  assign mem_bus.we = m_we & CE;
  assign mem_bus.wdata = m_wdata;

  // only the tool resets during a session
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s_reg <= '0;
      s_reg.fpcs <= FPCS_RST;
      s_reg.pins_free <= 1'b1;
    end else if (CE) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA = s_reg.prdata;
  assign PREADY = s_reg.pready;
  assign PSLVERR = s_reg.pslverr;
  assign SESSION_SERIAL_DATA_OUT = l_reg.dout;
  assign SESSION_SERIAL_DATA_OE = l_reg.oe;
  assign APP_PINS_FREE = s_reg.pins_free;
  assign READOUT_PROTECTED = s_reg.prot;
endmodule : fsa_top

// [verif/flash_sector_access_protection_test.sv]
// self-checking bench for the flash sector access block
// assumes an 8 Kbyte array so that erases stay short
`timescale 1ns/1ps
`define CHK(a, e) begin \
  n_tests++; \
  if ((a) !== (e)) begin \
    num_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module flash_sector_access_protection_test
  import fsa_pkg::*;
();
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic sck, dq, dout, oe, sel_vpp, present, pins_free, prot;
  logic [7:0] rep;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  fsa_top #(.FLASH_KB(8)) DUT (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SESSION_SERIAL_CLOCK(sck), .SESSION_SERIAL_DATA_IN(dq), .SESSION_SERIAL_DATA_OUT(dout),
    .SESSION_SERIAL_DATA_OE(oe), .SESSION_SELECT_PROG_VOLTAGE(sel_vpp),
    .TOOL_PRESENT(present), .APP_PINS_FREE(pins_free), .READOUT_PROTECTED(prot));
  fsa_tool_model tool (.sck(sck), .dq(dq), .dout(dout), .oe(oe), .sel_vpp(sel_vpp),
    .present(present));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // entered just after a rising edge; holds the request until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    apb(1'b0, idx, 32'h0, d, e);
  endtask : rd
  // polling busy rather than counting keeps the bench latency-free
  task automatic cpu(input fsa_op_type op, input logic [15:0] a, input logic [7:0] d);
    logic [31:0] s;
    wr(ADDR_IDX, {16'h0, a});
    wr(DATA_IDX, {24'h0, d});
    wr(CMD_IDX, {30'h0, op});
    s = 32'h1;
    for (int i = 0; i < 9000 && s[ST_BUSY] !== 1'b0; i++) rd(STAT_IDX, s);
    `CHK(s[ST_BUSY], 1'b0)
  endtask : cpu
  // reply of a frame belongs to the frame before it
  task automatic lk(input fsa_op_type op, input logic [15:0] a, input logic [7:0] d, input int w);
    tool.frame(op, a, d, rep);
    repeat (w) @(posedge clk);
  endtask : lk
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    // only the bench drives reset, never inside a session
    tool.pulse(4);
    @(posedge clk);
    rst_n <= 1'b1;
    tool.pulse(4);
    @(posedge clk);
    rd(FPCS_IDX, r);
    `CHK(r, 32'h0)
    wr(FPCS_IDX, 32'h0000_01a5);
    rd(FPCS_IDX, r);
    `CHK(r, 32'h0000_00a5)
    apb(1'b0, 8'h3f, 32'h0, r, e);
    `CHK(e, 1'b1)
    rd(STAT_IDX, r);
    `CHK(r[7:0], 8'h80)
    `CHK({pins_free, prot}, 2'b10)
    cpu(OP_PROG, SECT1_BASE, 8'h00);
    rd(STAT_IDX, r);
    `CHK(r[ST_REFUSED], 1'b1)
    tool.attach(1'b1);
    @(posedge clk);
    `CHK(pins_free, 1'b0)
    rd(STAT_IDX, r);
    `CHK(r[ST_TOOL:ST_SESSION], 3'b111)
    cpu(OP_ERASE, SECT0_BASE, 8'h00);
    rd(STAT_IDX, r);
    `CHK(r[ST_REFUSED], 1'b1)
    cpu(OP_ERASE, SECT1_BASE, 8'h00);
    rd(STAT_IDX, r);
    `CHK(r[ST_REFUSED], 1'b0)
    cpu(OP_PROG, 16'he005, 8'h3c);
    cpu(OP_READ, 16'he005, 8'h00);
    rd(DATA_IDX, r);
    `CHK(r, 32'h3c)
    cpu(OP_OPTION, 16'h0000, 8'h01);
    rd(STAT_IDX, r);
    `CHK(r[ST_PROT:ST_REFUSED], 2'b01)
    lk(OP_ERASE, SECT0_BASE, 8'h00, 4200);
    lk(OP_PROG, 16'hf010, 8'h5a, 20);
    `CHK(rep, REPLY_DONE)
    lk(OP_READ, 16'hf010, 8'h00, 20);
    `CHK(rep, REPLY_DONE)
    lk(OP_READ, 16'he005, 8'h00, 20);
    `CHK(rep, 8'h5a)
    lk(OP_PROG, 16'hd000, 8'h11, 20);
    `CHK(rep, 8'h3c)
    lk(OP_OPTION, 16'h0000, 8'h01, 20);
    `CHK(rep, REPLY_REFUSED)
    lk(OP_READ, 16'hf010, 8'h00, 20);
    `CHK(rep, REPLY_DONE)
    `CHK(prot, 1'b1)
    lk(OP_PROG, 16'he006, 8'h00, 20);
    `CHK(rep, 8'h00)
    lk(OP_OPTION, 16'h0000, 8'h00, 100);
    `CHK(rep, REPLY_REFUSED)
    // a frozen engine must keep protection through the whole erase time
    ce <= 1'b0;
    repeat (8300) @(posedge clk);
    `CHK(prot, 1'b1)
    ce <= 1'b1;
    repeat (8300) @(posedge clk);
    lk(OP_READ, 16'he005, 8'h00, 20);
    `CHK(rep, REPLY_DONE)
    `CHK(prot, 1'b0)
    lk(OP_READ, 16'he005, 8'h00, 20);
    `CHK(rep, ERASED_BYTE)
    tool.attach(1'b0);
    @(posedge clk);
    `CHK(pins_free, 1'b1)
    end_of_test();
  end
endmodule : flash_sector_access_protection_test

// [verif/fsa_tool_model.sv]
// behavioural programming tool on the far side of the session link
// assumes the device samples on rising link clock and replies from edge 26
`timescale 1ns/1ps
module fsa_tool_model (
  // link pins
  output logic sck,
  output logic dq,
  input wire logic dout,
  input wire logic oe,
  // session control
  output logic sel_vpp,
  output logic present
);
  initial begin
    sck = 1'b0;
    dq = 1'b0;
    sel_vpp = 1'b0;
    present = 1'b0;
  end
  // ----------------------------------------------------------------
  // link tasks
  // ----------------------------------------------------------------
  // idle edges, needed while the link logic resets; data keeps moving
  task automatic pulse(input int n);
    repeat (n) begin
      dq = ~dq;
      #16 sck = 1'b1;
      #16 sck = 1'b0;
    end
  endtask : pulse
  task automatic attach(input logic on);
    present = on;
    sel_vpp = on;
    // two edges let the select synchroniser settle, so frames start at bit 0
    pulse(2);
    #150;
  endtask : attach
  task automatic frame(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] rep);
    logic [25:0] cmd;
    cmd = {op, a, d};
    rep = 8'h00;
    for (int i = 0; i < 35; i++) begin
      if (i < 26) dq = cmd[25-i];
      #16 sck = 1'b1;
      #16 sck = 1'b0;
      if (i >= 26 && i < 34) rep = {rep[6:0], (oe === 1'b1) ? dout : 1'bx};
    end
    // released line must not keep the last bit
    dq = ~dq;
  endtask : frame
endmodule : fsa_tool_model

// [verif/fsa_top_assertions.sv]
// checker for the flash access block, top ports only
// assumes no apb transfer while CE is low and an apb master keeping setup/access order
`timescale 1ns/1ps
module fsa_top_assertions
  import fsa_pkg::*;
#(
  parameter int FLASH_KB = 8
) (
  // system
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // link
  input wire logic SESSION_SERIAL_CLOCK,
  input wire logic SESSION_SERIAL_DATA_IN,
  input wire logic SESSION_SERIAL_DATA_OUT,
  input wire logic SESSION_SERIAL_DATA_OE,
  input wire logic SESSION_SELECT_PROG_VOLTAGE,
  input wire logic TOOL_PRESENT,
  // status
  input wire logic APP_PINS_FREE,
  input wire logic READOUT_PROTECTED
);
  localparam logic [11:0] FPCS_ADDR = {2'b00, FPCS_IDX, 2'b00};
  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  a_ready_one_wait: assert property (@(posedge CLK) disable iff (!RST_N)
    (PSEL && PENABLE && !$past(PENABLE)) |-> !PREADY ##1 PREADY)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
    PREADY |=> !PREADY) else $error("pready longer than one cycle");
  a_ready_in_access: assert property (@(posedge CLK) disable iff (!RST_N)
    PREADY |-> PSEL && PENABLE) else $error("pready outside access phase");
  a_err_no_data: assert property (@(posedge CLK) disable iff (!RST_N)
    PREADY && PSLVERR |-> PRDATA == 32'h0) else $error("error answer carries data");
  a_tool_reg_width: assert property (@(posedge CLK) disable iff (!RST_N)
    PREADY && !PWRITE && PADDR == FPCS_ADDR |-> PRDATA[31:8] == 24'h0)
    else $error("tool register wider than 8 bits");
  // ----------------------------------------------------------------
  // session pins and protection
  // ----------------------------------------------------------------
  a_pins_taken: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(TOOL_PRESENT) |-> ##[1:4] !APP_PINS_FREE) else $error("pins not withheld");
  a_pins_held: assert property (@(posedge CLK) disable iff (!RST_N)
    TOOL_PRESENT [*5] |-> !APP_PINS_FREE) else $error("pins freed with tool present");
  a_prot_no_tool: assert property (@(posedge CLK) disable iff (!RST_N)
    (!TOOL_PRESENT) [*8] |=> $stable(READOUT_PROTECTED))
    else $error("protection changed without tool");
  a_oe_idle: assert property (@(posedge SESSION_SERIAL_CLOCK) disable iff (!RST_N)
    (!SESSION_SELECT_PROG_VOLTAGE) [*3] |-> !SESSION_SERIAL_DATA_OE)
    else $error("link driven outside session");
  a_reply_span: assert property (@(posedge SESSION_SERIAL_CLOCK) disable iff (!RST_N)
    $rose(SESSION_SERIAL_DATA_OE) |-> SESSION_SERIAL_DATA_OE [*8] ##1 !SESSION_SERIAL_DATA_OE)
    else $error("reply not eight bits long");
  c_refused: cover property (@(posedge CLK) PREADY && PSLVERR);
  c_protect: cover property (@(posedge CLK) $rose(READOUT_PROTECTED));
  c_reply: cover property (@(posedge SESSION_SERIAL_CLOCK) $fell(SESSION_SERIAL_DATA_OE));
endmodule : fsa_top_assertions

bind fsa_top fsa_top_assertions #(.FLASH_KB(FLASH_KB)) u_fsa_chk (
  .CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SESSION_SERIAL_CLOCK(SESSION_SERIAL_CLOCK),
  .SESSION_SERIAL_DATA_IN(SESSION_SERIAL_DATA_IN),
  .SESSION_SERIAL_DATA_OUT(SESSION_SERIAL_DATA_OUT),
  .SESSION_SERIAL_DATA_OE(SESSION_SERIAL_DATA_OE),
  .SESSION_SELECT_PROG_VOLTAGE(SESSION_SELECT_PROG_VOLTAGE), .TOOL_PRESENT(TOOL_PRESENT),
  .APP_PINS_FREE(APP_PINS_FREE), .READOUT_PROTECTED(READOUT_PROTECTED));
